// ### rtl/fe45_pkg.sv
// Constants, code-group tables and state types of the 100 Mb/s 4B/5B codec.
// Assumes one 250 MHz clock; nibble and symbol rates come from enable pulses.
// Function
// - Each data nibble maps to its fixed 5-bit code-group and back.
// - Idle is code-group 11111 and stands for nibble 0000.
// - First start symbol is 11000 and stands for nibble 0101.
// - Second start symbol is 10001, also nibble 0101.
// - First end symbol is 01101, nibble 0000.
// - Second end symbol is 00111, nibble 0000, closing the end pair.
// - Code-group 00100 is the halt symbol and marks an error.
// - Ten listed code-groups are invalid and carry no nibble value.
// - Transmit line output is MLT-3 only; no plain binary option.
// - Receive path turns the 125 Mb/s serial stream into nibbles.
// - Receiver offers descrambler bypass and decoder bypass selections.
// - Link pulses must not raise the signal-present indication.
// - Transmit replaces first preamble byte with the start pair.
// - On enable drop send end pair, then idles until enable returns.
// - Start pair after idles becomes 0101 0101; end pair or two idles stop.
// - Non-idle without start pair gives error and 1110 until two idles.
package fe45_pkg;

  // Special code-groups
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J    = 5'h18;
  localparam logic [4:0] CG_K    = 5'h11;
  localparam logic [4:0] CG_T    = 5'h0d;
  localparam logic [4:0] CG_R    = 5'h07;
  localparam logic [4:0] CG_H    = 5'h04;
  localparam logic [9:0] CG_JK   = {CG_J, CG_K};
  localparam logic [9:0] CG_TR   = {CG_T, CG_R};
  localparam logic [9:0] CG_II   = {CG_IDLE, CG_IDLE};

  // Nibbles presented to the MAC
  localparam logic [3:0] NIB_PRE   = 4'h5;
  localparam logic [3:0] NIB_ZERO  = 4'h0;
  localparam logic [3:0] NIB_FALSE = 4'he;

  // Rates and dividers
  localparam int CLK_MHZ     = 250;
  localparam int NIB_MHZ     = 25;
  localparam int SYM_MHZ     = 125;
  localparam int NIB_DIV     = CLK_MHZ / NIB_MHZ;
  localparam int SYM_DIV     = CLK_MHZ / SYM_MHZ;
  localparam int SYM_BITS    = 5;
  localparam logic [3:0] NIB_DIV_LAST = 4'(NIB_DIV - 1);
  localparam logic [2:0] GRP_LAST     = 3'(SYM_BITS - 1);

  // Energy must persist longer than any link pulse before counting as signal
  localparam int PULSE_REJECT_NS  = 200;
  localparam int PULSE_REJECT_CYC = (PULSE_REJECT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PULSE_REJECT_LAST = 8'(PULSE_REJECT_CYC);

  // Descrambler lock: twelve consecutive idles worth of matching bits
  localparam int IDLES_TO_LOCK = 12;
  localparam logic [6:0] LOCK_BITS = 7'(IDLES_TO_LOCK * SYM_BITS);

  // Scrambler polynomial x^11 + x^9 + 1
  localparam int         SCR_W     = 11;
  localparam int         SCR_TAP_A = 10;
  localparam int         SCR_TAP_B = 8;
  localparam logic [10:0] SCR_SEED = 11'h7ff;

  // Transmit buffer word: {enable, error, nibble}
  localparam int TXW_W     = 6;
  localparam int TXW_EN    = 5;
  localparam int TXW_ER    = 4;
  localparam int FIFO_DEPTH = 16;

  // Transmit sequencer
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_K    = 2'b01,
    TX_DATA = 2'b10,
    TX_R    = 2'b11
  } fe45_tx_state_t;

  // Receive sequencer
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_PKT   = 2'b01,
    RX_FALSE = 2'b10
  } fe45_rx_state_t;

  // Nibble to data code-group
  function automatic logic [4:0] enc_nib(input logic [3:0] n);
    logic [4:0] c;
    c = CG_IDLE;
    case (n)
      4'h0: c = 5'h1e;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0a;
      4'h5: c = 5'h0b;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'ha: c = 5'h16;
      4'hb: c = 5'h17;
      4'hc: c = 5'h1a;
      4'hd: c = 5'h1b;
      4'he: c = 5'h1c;
      default: c = 5'h1d;
    endcase
    return c;
  endfunction

  // Code-group to {error, nibble}; halt and invalid groups carry error
  function automatic logic [4:0] dec_cg(input logic [4:0] c);
    logic [4:0] r;
    r = {1'b1, NIB_ZERO};
    case (c)
      5'h1e: r = 5'h00;
      5'h09: r = 5'h01;
      5'h14: r = 5'h02;
      5'h15: r = 5'h03;
      5'h0a: r = 5'h04;
      5'h0b: r = 5'h05;
      5'h0e: r = 5'h06;
      5'h0f: r = 5'h07;
      5'h12: r = 5'h08;
      5'h13: r = 5'h09;
      5'h16: r = 5'h0a;
      5'h17: r = 5'h0b;
      5'h1a: r = 5'h0c;
      5'h1b: r = 5'h0d;
      5'h1c: r = 5'h0e;
      5'h1d: r = 5'h0f;
      CG_IDLE, CG_T, CG_R: r = {1'b0, NIB_ZERO};
      CG_J, CG_K:          r = {1'b0, NIB_PRE};
      default:             r = {1'b1, NIB_ZERO};
    endcase
    return r;
  endfunction

endpackage

// ### rtl/fe45_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/100ps
module fe45_fifo #(
  parameter int W = 6,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // Honest flags straight from the fill count
  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ### rtl/fe45_codec.sv
// 4B/5B encoder and decoder with scrambler, NRZI and MLT-3 line stage.
// Assumes rx_bit/rx_bit_valid come from clock recovery on clk;
// line_energy and bypass selections are pins and are synchronised here.
`timescale 1ns/100ps
module fe45_codec (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // MAC transmit words
  input  wire logic       mac_tx_valid,
  output logic            mac_tx_ready,
  input  wire logic       mac_tx_en,
  input  wire logic       mac_tx_er,
  input  wire logic [3:0] mac_txd,
  // Line transmit, MLT-3 level as separate plus and minus flags
  output logic            tx_mlt3_pos,
  output logic            tx_mlt3_neg,
  // Line receive
  input  wire logic       rx_bit,
  input  wire logic       rx_bit_valid,
  input  wire logic       line_energy,
  // Configuration pins
  input  wire logic       scrambler_bypass_select,
  input  wire logic       codec_bypass_select,
  // MAC receive
  output logic            rx_nib_stb,
  output logic            rx_dv,
  output logic            rx_er,
  output logic [3:0]      rxd,
  output logic            line_signal_present
);

  // Pin synchronisers; the first stage feeds only the second
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic       energy_s;
  logic       scr_byp;
  logic       cdc_byp;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end
    else
    begin
      pin_s1_reg <= {line_energy, scrambler_bypass_select, codec_bypass_select};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign energy_s = pin_s2_reg[2];
  assign scr_byp  = pin_s2_reg[1];
  assign cdc_byp  = pin_s2_reg[0];

  // Rate divider: nibble enable every 10 cycles, bit enable every 2
  logic [3:0] div_reg;
  logic       nib_en;
  logic       bit_en;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      div_reg <= 4'h0;
    end
    else
    begin
      div_reg <= (div_reg == fe45_pkg::NIB_DIV_LAST) ? 4'h0 : div_reg + 4'h1;
    end
  end

  assign nib_en = (div_reg == 4'h0);
  assign bit_en = (div_reg[0] == 1'b0);

  // Transmit buffer; the encoder drains one word per nibble period, none during the second end symbol
  logic                      fifo_valid;
  logic                      fifo_pop;
  logic [fe45_pkg::TXW_W-1:0] fifo_word;
  logic [fe45_pkg::TXW_W-1:0] tx_word;
  fe45_pkg::fe45_tx_state_t  tx_state_reg;

  fe45_fifo #(
    .W (fe45_pkg::TXW_W),
    .D (fe45_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (mac_tx_valid),
    .in_ready  (mac_tx_ready),
    .in_data   ({mac_tx_en, mac_tx_er, mac_txd}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_word)
  );

  // The second end symbol takes a slot of its own, so no word is consumed
  assign fifo_pop = nib_en & (tx_state_reg != fe45_pkg::TX_R);
  // An empty buffer reads as enable low, which keeps idles flowing
  assign tx_word  = fifo_valid ? fifo_word : '0;

  // Code-group chosen for the coming nibble period
  logic [4:0]               tx_code;
  fe45_pkg::fe45_tx_state_t tx_state_next;
  logic                     w_en;
  logic                     w_er;
  logic [3:0]               w_d;

  assign w_en = tx_word[fe45_pkg::TXW_EN];
  assign w_er = tx_word[fe45_pkg::TXW_ER];
  assign w_d  = tx_word[3:0];

  always_comb
  begin
    tx_code       = fe45_pkg::CG_IDLE;
    tx_state_next = tx_state_reg;
    if (cdc_byp)
    begin
      tx_code       = w_en ? {w_er, w_d} : fe45_pkg::CG_IDLE;
      tx_state_next = fe45_pkg::TX_IDLE;
    end
    else
    begin
      unique case (tx_state_reg)
        fe45_pkg::TX_IDLE:
        begin
          if (w_en)
          begin
            tx_code       = fe45_pkg::CG_J;
            tx_state_next = fe45_pkg::TX_K;
          end
          else
          begin
            tx_code = fe45_pkg::CG_IDLE;
          end
        end
        fe45_pkg::TX_K:
        begin
          if (w_en)
          begin
            tx_code       = fe45_pkg::CG_K;
            tx_state_next = fe45_pkg::TX_DATA;
          end
          else
          begin
            tx_code       = fe45_pkg::CG_T;
            tx_state_next = fe45_pkg::TX_R;
          end
        end
        fe45_pkg::TX_DATA:
        begin
          if (w_en)
          begin
            // Error from the MAC is sent as halt
            tx_code = w_er ? fe45_pkg::CG_H : fe45_pkg::enc_nib(w_d);
          end
          else
          begin
            tx_code       = fe45_pkg::CG_T;
            tx_state_next = fe45_pkg::TX_R;
          end
        end
        fe45_pkg::TX_R:
        begin
          tx_code       = fe45_pkg::CG_R;
          tx_state_next = fe45_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Transmit sequencer
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_state_reg <= fe45_pkg::TX_IDLE;
    end
    else if (nib_en)
    begin
      tx_state_reg <= tx_state_next;
    end
  end

  // Serialiser, most significant bit first
  logic [4:0] tx_sh_reg;
  logic       tx_nrz;

  assign tx_nrz = nib_en ? tx_code[4] : tx_sh_reg[4];

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_sh_reg <= fe45_pkg::CG_IDLE;
    end
    else if (nib_en)
    begin
      tx_sh_reg <= {tx_code[3:0], 1'b0};
    end
    else if (bit_en)
    begin
      tx_sh_reg <= {tx_sh_reg[3:0], 1'b0};
    end
  end

  // Transmit scrambler; runs free so a bypass toggle does not lose sync
  logic [fe45_pkg::SCR_W-1:0] tx_lfsr_reg;
  logic                       tx_key;
  logic                       tx_sd;

  assign tx_key = tx_lfsr_reg[fe45_pkg::SCR_TAP_A] ^ tx_lfsr_reg[fe45_pkg::SCR_TAP_B];
  assign tx_sd  = tx_nrz ^ (tx_key & ~scr_byp);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_lfsr_reg <= fe45_pkg::SCR_SEED;
    end
    else if (bit_en)
    begin
      tx_lfsr_reg <= {tx_lfsr_reg[fe45_pkg::SCR_W-2:0], tx_key};
    end
  end

  // NRZI then MLT-3; a one steps the level 0, +, 0, - with no binary path
  logic [1:0] mlt_phase_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      mlt_phase_reg <= 2'h0;
      tx_mlt3_pos   <= 1'b0;
      tx_mlt3_neg   <= 1'b0;
    end
    else if (bit_en && tx_sd)
    begin
      mlt_phase_reg <= mlt_phase_reg + 2'h1;
      tx_mlt3_pos   <= (mlt_phase_reg == 2'h0);
      tx_mlt3_neg   <= (mlt_phase_reg == 2'h2);
    end
  end

  // Signal present only after energy outlasts any link pulse
  logic [7:0] sd_cnt_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sd_cnt_reg          <= 8'h00;
      line_signal_present <= 1'b0;
    end
    else if (!energy_s)
    begin
      sd_cnt_reg          <= 8'h00;
      line_signal_present <= 1'b0;
    end
    else if (sd_cnt_reg != fe45_pkg::PULSE_REJECT_LAST)
    begin
      sd_cnt_reg <= sd_cnt_reg + 8'h01;
    end
    else
    begin
      line_signal_present <= 1'b1;
    end
  end

  // Receive descrambler; locks by assuming idle ones on the line
  logic [fe45_pkg::SCR_W-1:0] rx_lfsr_reg;
  logic [6:0]                 lock_cnt_reg;
  logic                       locked_reg;
  logic                       rx_key;
  logic                       rx_ud;
  logic                       rx_shift;

  assign rx_key   = rx_lfsr_reg[fe45_pkg::SCR_TAP_A] ^ rx_lfsr_reg[fe45_pkg::SCR_TAP_B];
  assign rx_shift = rx_bit_valid & line_signal_present;

  // Unlocked data is held at idle so no false carrier is reported
  always_comb
  begin
    if (scr_byp)
    begin
      rx_ud = rx_bit;
    end
    else
    begin
      rx_ud = locked_reg ? (rx_bit ^ rx_key) : 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn || !line_signal_present)
    begin
      rx_lfsr_reg  <= fe45_pkg::SCR_SEED;
      lock_cnt_reg <= 7'h00;
      locked_reg   <= 1'b0;
    end
    else if (rx_bit_valid)
    begin
      if (locked_reg)
      begin
        rx_lfsr_reg <= {rx_lfsr_reg[fe45_pkg::SCR_W-2:0], rx_key};
      end
      else
      begin
        rx_lfsr_reg <= {rx_lfsr_reg[fe45_pkg::SCR_W-2:0], ~rx_bit};
        lock_cnt_reg <= (rx_bit ^ rx_key) ? lock_cnt_reg + 7'h01 : 7'h00;
        locked_reg   <= (lock_cnt_reg == fe45_pkg::LOCK_BITS);
      end
    end
  end

  // Ten-bit window; the oldest five bits form the group under decode
  logic [9:0]               win_reg;
  logic [9:0]               win_next;
  logic [2:0]               grp_cnt_reg;
  logic                     grp_end;
  logic                     rx_end;
  fe45_pkg::fe45_rx_state_t rx_state_reg;

  assign win_next = {win_reg[8:0], rx_ud};
  assign grp_end  = (grp_cnt_reg == fe45_pkg::GRP_LAST);
  // A closing end pair is flushed so its zeros cannot mimic a false start
  assign rx_end   = grp_end && (rx_state_reg == fe45_pkg::RX_PKT)
                    && (win_next == fe45_pkg::CG_TR);

  always_ff @(posedge clk)
  begin
    if (!resetn || !line_signal_present)
    begin
      win_reg <= fe45_pkg::CG_II;
    end
    else if (rx_shift)
    begin
      win_reg <= rx_end ? fe45_pkg::CG_II : win_next;
    end
  end

  // Receive sequencer and nibble outputs
  logic [4:0] dec;

  assign dec = fe45_pkg::dec_cg(win_next[9:5]);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_state_reg <= fe45_pkg::RX_IDLE;
      grp_cnt_reg  <= 3'h0;
      rx_nib_stb   <= 1'b0;
      rx_dv        <= 1'b0;
      rx_er        <= 1'b0;
      rxd          <= 4'h0;
    end
    else if (!line_signal_present)
    begin
      // Loss of signal ends any packet at once
      rx_nib_stb   <= rx_dv;
      rx_state_reg <= fe45_pkg::RX_IDLE;
      rx_dv        <= 1'b0;
      rx_er        <= 1'b0;
    end
    else
    begin
      rx_nib_stb <= 1'b0;
      if (rx_shift)
      begin
        grp_cnt_reg <= grp_end ? 3'h0 : grp_cnt_reg + 3'h1;
        unique case (rx_state_reg)
          fe45_pkg::RX_IDLE:
          begin
            if (win_next == fe45_pkg::CG_JK)
            begin
              rx_state_reg <= fe45_pkg::RX_PKT;
              grp_cnt_reg  <= 3'h0;
              rx_nib_stb   <= 1'b1;
              rx_dv        <= 1'b1;
              rx_er        <= cdc_byp & win_next[9];
              rxd          <= cdc_byp ? win_next[8:5] : fe45_pkg::NIB_PRE;
            end
            else if (!(&win_next[9:7]))
            begin
              // A zero reached the spot where a start pair would be complete
              rx_state_reg <= fe45_pkg::RX_FALSE;
              grp_cnt_reg  <= 3'h0;
              rx_nib_stb   <= 1'b1;
              rx_dv        <= 1'b1;
              rx_er        <= cdc_byp ? win_next[9] : 1'b1;
              rxd          <= cdc_byp ? win_next[8:5] : fe45_pkg::NIB_FALSE;
            end
          end
          fe45_pkg::RX_PKT:
          begin
            if (grp_end)
            begin
              rx_nib_stb <= 1'b1;
              if (win_next == fe45_pkg::CG_TR || win_next == fe45_pkg::CG_II)
              begin
                rx_state_reg <= fe45_pkg::RX_IDLE;
                rx_dv        <= 1'b0;
                rx_er        <= 1'b0;
              end
              else if (cdc_byp)
              begin
                rx_er <= win_next[9];
                rxd   <= win_next[8:5];
              end
              else
              begin
                rx_er <= dec[4];
                rxd   <= dec[3:0];
              end
            end
          end
          fe45_pkg::RX_FALSE:
          begin
            if (grp_end)
            begin
              rx_nib_stb <= 1'b1;
              if (win_next == fe45_pkg::CG_II)
              begin
                rx_state_reg <= fe45_pkg::RX_IDLE;
                rx_dv        <= 1'b0;
                rx_er        <= 1'b0;
              end
              else
              begin
                rx_er <= cdc_byp ? win_next[9] : 1'b1;
                rxd   <= cdc_byp ? win_next[8:5] : fe45_pkg::NIB_FALSE;
              end
            end
          end
          default:
          begin
            rx_state_reg <= fe45_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### verif/fe45_mac_model.sv
// MAC-side transmit model: queues words, offers them by valid/ready.
// Assumes the codec samples its inputs on the rising clock edge.
`timescale 1ns/100ps
module fe45_mac_model (
  // Clock and pacing
  input  wire logic       clk,
  input  wire logic       slow,
  // Transmit word handshake
  output logic            mac_tx_valid,
  input  wire logic       mac_tx_ready,
  output logic            mac_tx_en,
  output logic            mac_tx_er,
  output logic [3:0]      mac_txd
);
  logic [5:0] word_q[$];
  logic       taken;

  initial
  begin
    mac_tx_valid = 1'b0;
    {mac_tx_en, mac_tx_er, mac_txd} = 6'h00;
  end

  // Word held until taken; slow pacing leaves a gap after each take
  always @(posedge clk)
  begin
    taken = mac_tx_valid && mac_tx_ready;
    if (taken)
      void'(word_q.pop_front());
    if (word_q.size() > 0 && !(slow && taken))
    begin
      mac_tx_valid <= 1'b1;
      {mac_tx_en, mac_tx_er, mac_txd} <= word_q[0];
    end
    else
    begin
      mac_tx_valid <= 1'b0;
      {mac_tx_en, mac_tx_er, mac_txd} <= ~{mac_tx_en, mac_tx_er, mac_txd}; // No stale word
    end
  end

  // Queue one {enable, error, nibble} word
  task automatic push(input logic [5:0] w);
    word_q.push_back(w);
  endtask
endmodule

// ### verif/fe45_codec_asserts.sv
// Concurrent checks on the codec's line and MAC receive ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
module fe45_codec_asserts (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Line side
  input wire logic       tx_mlt3_pos,
  input wire logic       tx_mlt3_neg,
  input wire logic       rx_bit_valid,
  input wire logic       line_energy,
  input wire logic       codec_bypass_select,
  // MAC receive side
  input wire logic       rx_nib_stb,
  input wire logic       rx_dv,
  input wire logic       rx_er,
  input wire logic [3:0] rxd,
  input wire logic       line_signal_present
);
  logic [7:0] energy_cnt_reg;

  // Run of raw energy cycles; saturates so a long link cannot wrap
  always_ff @(posedge clk)
  begin
    if (!resetn || !line_energy)
      energy_cnt_reg <= 8'h00;
    else if (energy_cnt_reg != 8'hff)
      energy_cnt_reg <= energy_cnt_reg + 8'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_MLT3_EXCL: assert property (!(tx_mlt3_pos && tx_mlt3_neg))
    else $error("both line levels high");
  AST_MLT3_STEP: assert property (tx_mlt3_pos |=> !tx_mlt3_neg)
    else $error("line level skipped zero");
  AST_MLT3_RATE: assert property ($past(resetn) && $changed({tx_mlt3_pos, tx_mlt3_neg})
    |=> $stable({tx_mlt3_pos, tx_mlt3_neg})) else $error("line level changed too fast");
  AST_STB_PULSE: assert property (rx_nib_stb |=> !rx_nib_stb)
    else $error("nibble strobe too long");
  AST_NIB_FROM_BIT: assert property (rx_nib_stb && rx_dv |-> $past(rx_bit_valid))
    else $error("nibble without a bit");
  AST_NIB_HOLD: assert property ($past(resetn) && !rx_nib_stb
    |-> $stable({rx_dv, rx_er, rxd})) else $error("nibble changed without strobe");
  AST_ERR_NIB: assert property (!codec_bypass_select [*5] ##0 (rx_nib_stb && rx_er)
    |-> rxd == 4'h0 || rxd == 4'he) else $error("error nibble value");
  AST_END_CLEAN: assert property (rx_nib_stb && !rx_dv |-> !rx_er)
    else $error("end of packet flagged error");
  AST_LSP_QUAL: assert property ($rose(line_signal_present) |-> energy_cnt_reg >= 8'h32)
    else $error("signal present on short energy");
  AST_LSP_DROP: assert property (!line_energy [*4] |-> !line_signal_present)
    else $error("signal present without energy");
endmodule

bind fe45_codec fe45_codec_asserts chk_u (
  .clk, .resetn, .tx_mlt3_pos, .tx_mlt3_neg, .rx_bit_valid, .line_energy,
  .codec_bypass_select, .rx_nib_stb, .rx_dv, .rx_er, .rxd, .line_signal_present
);

// ### verif/fe45_codec_tb.sv
// Self-checking bench: receive decode, transmit encode, signal qualification.
// Assumes the MAC model beside the codec and the checker bound into it.
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    n_tests++; \
    if ((a) !== (e)) \
    begin \
      n_fail++; \
      $display("wrong value at %0t: got %h expected %h", $time, a, e); \
    end \
  end
module fe45_codec_tb;
  localparam logic [4:0] DATA_CG [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [4:0] BAD_CG [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08,
    5'h0c, 5'h10, 5'h19};
  logic clk, resetn, slow, rx_bit, rx_bit_valid, line_energy, seen_full, ph, hunt;
  logic scrambler_bypass_select, codec_bypass_select, mac_tx_valid, mac_tx_ready;
  logic mac_tx_en, mac_tx_er, tx_mlt3_pos, tx_mlt3_neg, rx_nib_stb, rx_dv, rx_er;
  logic line_signal_present;
  logic [3:0] mac_txd, rxd;
  logic [1:0] lvl_old;
  logic [9:0] win;
  logic [5:0] rxq[$];
  logic [4:0] txq[$];
  int n_fail, n_tests, nb;

  fe45_codec dut_u (.clk, .resetn, .mac_tx_valid, .mac_tx_ready, .mac_tx_en, .mac_tx_er,
    .mac_txd, .tx_mlt3_pos, .tx_mlt3_neg, .rx_bit, .rx_bit_valid, .line_energy,
    .scrambler_bypass_select, .codec_bypass_select, .rx_nib_stb, .rx_dv, .rx_er, .rxd,
    .line_signal_present);
  fe45_mac_model mac_u (.clk, .slow, .mac_tx_valid, .mac_tx_ready, .mac_tx_en, .mac_tx_er,
    .mac_txd);

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Received nibbles and buffer-full sightings
  always @(posedge clk)
  begin
    if (rx_nib_stb)
      rxq.push_back({rx_dv, rx_er, rxd});
    if (resetn && !mac_tx_ready)
      seen_full = 1'b1;
  end

  // Line decode: any level step within a two-clock bit is a one
  always @(posedge clk)
  begin
    ph = resetn && !ph;
    if (!resetn)
      {hunt, nb, lvl_old, win} = {1'b1, 32'd0, 2'b00, 10'h000};
    else if (ph)
    begin
      win = {win[8:0], {tx_mlt3_pos, tx_mlt3_neg} != lvl_old};
      lvl_old = {tx_mlt3_pos, tx_mlt3_neg};
      nb++;
      if (hunt && win == fe45_pkg::CG_JK)
        {hunt, nb} = {1'b0, 32'd0};
      else if (!hunt && nb == 5)
      begin
        nb = 0;
        if (win[4:0] == fe45_pkg::CG_IDLE)
          hunt = 1'b1;
        else
          txq.push_back(win[4:0]);
      end
    end
  end

  // One code-group, MSB first, one bit every two clocks
  task automatic send_cg(input logic [4:0] c, input int n = 1);
    repeat (n)
      for (int i = 4; i >= 0; i--)
      begin
        rx_bit <= c[i];
        rx_bit_valid <= 1'b1;
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        @(posedge clk);
      end
  endtask

  // Compare the oldest received nibble under a mask
  task automatic pop_chk(input logic [5:0] e, input logic [5:0] m = 6'h3f);
    logic [5:0] g;
    g = (rxq.size() > 0) ? rxq.pop_front() : 6'bx;
    `CHK(g & m, e)
  endtask

  task automatic signal_present();
    line_energy <= 1'b1;
    repeat (49) @(posedge clk);
    line_energy <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(line_signal_present, 1'b0)
    line_energy <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK(line_signal_present, 1'b1)
  endtask

  task automatic rx_packet();
    send_cg(fe45_pkg::CG_IDLE, 3);
    send_cg(fe45_pkg::CG_J);
    send_cg(fe45_pkg::CG_K);
    foreach (DATA_CG[k]) send_cg(DATA_CG[k]);
    send_cg(fe45_pkg::CG_H);
    foreach (BAD_CG[k]) send_cg(BAD_CG[k]);
    send_cg(fe45_pkg::CG_T);
    send_cg(fe45_pkg::CG_R);
    send_cg(fe45_pkg::CG_IDLE, 3);
    pop_chk(6'h25);
    pop_chk(6'h25);
    for (int k = 0; k < 16; k++) pop_chk({2'b10, 4'(k)});
    pop_chk(6'h30);
    for (int k = 0; k < 10; k++) pop_chk(6'h30);
    pop_chk(6'h00, 6'h30);
    `CHK(rxq.size(), 0)
  endtask

  task automatic rx_idle_end();
    send_cg(fe45_pkg::CG_J);
    send_cg(fe45_pkg::CG_K);
    send_cg(DATA_CG[9]);
    send_cg(fe45_pkg::CG_IDLE, 3);
    pop_chk(6'h25);
    pop_chk(6'h25);
    pop_chk(6'h29);
    pop_chk(6'h00, 6'h30);
    `CHK(rxq.size(), 0)
  endtask

  task automatic rx_false_start();
    send_cg(DATA_CG[3]);
    send_cg(DATA_CG[4]);
    send_cg(fe45_pkg::CG_IDLE, 4);
    `CHK(rxq.size() >= 2, 1'b1)
    while (rxq.size() > 1) pop_chk(6'h3e);
    pop_chk(6'h00, 6'h30);
  endtask

  task automatic rx_bypass();
    codec_bypass_select <= 1'b1;
    repeat (4) @(posedge clk);
    send_cg(fe45_pkg::CG_J);
    send_cg(fe45_pkg::CG_K);
    send_cg(5'h1c);
    send_cg(fe45_pkg::CG_H);
    send_cg(fe45_pkg::CG_IDLE, 3);
    pop_chk(6'h38);
    pop_chk(6'h31);
    pop_chk(6'h3c);
    pop_chk(6'h24);
    rxq.delete();
    codec_bypass_select <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Frame of two preamble words, n data words, an error word, then enable low
  task automatic tx_frame(input logic [3:0] f, input int n, input logic s);
    int w;
    slow <= s;
    txq.delete();
    mac_u.push(6'h25);
    mac_u.push(6'h25);
    for (int k = 0; k < n; k++) mac_u.push({2'b10, 4'(k) ^ f});
    mac_u.push(6'h30);
    mac_u.push(6'h00);
    w = 0;
    while (txq.size() < n + 3 && w < 3000)
    begin
      @(posedge clk);
      w++;
    end
    for (int k = 0; k < n; k++) `CHK(txq[k], DATA_CG[4'(k) ^ f])
    `CHK(txq[n], fe45_pkg::CG_H)
    `CHK(txq[n + 1], fe45_pkg::CG_T)
    `CHK(txq[n + 2], fe45_pkg::CG_R)
    repeat (60) @(posedge clk);
    `CHK(txq.size(), n + 3)
    `CHK(mac_tx_ready, 1'b1)
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end

  // Main sequence
  initial
  begin
    {n_fail, n_tests, seen_full, resetn, slow, rx_bit, rx_bit_valid} = '0;
    {line_energy, codec_bypass_select, scrambler_bypass_select} = 3'b001;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    signal_present();
    rx_packet();
    rx_idle_end();
    rx_false_start();
    rx_bypass();
    tx_frame(4'h0, 16, 1'b0);
    `CHK(seen_full, 1'b1)
    tx_frame(4'hc, 3, 1'b1);
    final_report();
  end
endmodule
